// [hdl/icrp_decode.sv]
// index decoder: which register an index selects and whether it is claimed
`timescale 1ns/100ps
`include "icrp_defs.svh"
module icrp_decode
    import icrp_pkg::*;
(
    input wire logic [7:0] index,
    input wire logic extendedMapEnable,
    output logic claimed,
    output icrp_sel_t regSel
);

    // map index to register; unknown indices give no select
    always_comb
    begin
        unique case (index)
            `ICRP_IDX_PERF_CONTROL: regSel = SEL_PERF;
            `ICRP_IDX_SMM_HEADER_0: regSel = SEL_HDR0;
            `ICRP_IDX_SMM_HEADER_1: regSel = SEL_HDR1;
            `ICRP_IDX_SMM_HEADER_2: regSel = SEL_HDR2;
            `ICRP_IDX_SMM_HEADER_3: regSel = SEL_HDR3;
            `ICRP_IDX_GRAPHICS_CONTROL: regSel = SEL_GFX;
            `ICRP_IDX_VGA_TRAP_CONTROL: regSel = SEL_VTRAP;
            `ICRP_IDX_VGA_TRAP_MASK_0: regSel = SEL_VMASK0;
            `ICRP_IDX_VGA_TRAP_MASK_1: regSel = SEL_VMASK1;
            `ICRP_IDX_VGA_TRAP_MASK_2: regSel = SEL_VMASK2;
            `ICRP_IDX_VGA_TRAP_MASK_3: regSel = SEL_VMASK3;
            `ICRP_IDX_CONFIG_1: regSel = SEL_CFG1;
            `ICRP_IDX_CONFIG_2: regSel = SEL_CFG2;
            `ICRP_IDX_CONFIG_3: regSel = SEL_CFG3;
            `ICRP_IDX_SMM_REGION_0: regSel = SEL_REGION0;
            `ICRP_IDX_SMM_REGION_1: regSel = SEL_REGION1;
            `ICRP_IDX_SMM_REGION_2: regSel = SEL_REGION2;
            `ICRP_IDX_CONFIG_4: regSel = SEL_CFG4;
            `ICRP_IDX_CONFIG_7: regSel = SEL_CFG7;
            `ICRP_IDX_DEVICE_IDENT_0: regSel = SEL_IDENT0;
            `ICRP_IDX_DEVICE_IDENT_1: regSel = SEL_IDENT1;
            default: regSel = SEL_NONE;
        endcase
    end

    // base window and identification indices always claimed; the rest only with map enable set
    always_comb
    begin
        claimed = (index[7:4] == `ICRP_IDX_BASE_HIGH) || (index == `ICRP_IDX_DEVICE_IDENT_0)
            || (index == `ICRP_IDX_DEVICE_IDENT_1) || (extendedMapEnable && (regSel != SEL_NONE));
    end

endmodule : icrp_decode

// [hdl/icrp_defs.svh]
// constants of the indexed configuration register port
`ifndef ICRP_DEFS_SVH
`define ICRP_DEFS_SVH

`define ICRP_PORT_INDEX 16'h0022
`define ICRP_PORT_DATA 16'h0023

`define ICRP_IDX_PERF_CONTROL 8'h20
`define ICRP_IDX_SMM_HEADER_0 8'hb0
`define ICRP_IDX_SMM_HEADER_1 8'hb1
`define ICRP_IDX_SMM_HEADER_2 8'hb2
`define ICRP_IDX_SMM_HEADER_3 8'hb3
`define ICRP_IDX_GRAPHICS_CONTROL 8'hb8
`define ICRP_IDX_VGA_TRAP_CONTROL 8'hb9
`define ICRP_IDX_VGA_TRAP_MASK_0 8'hba
`define ICRP_IDX_VGA_TRAP_MASK_1 8'hbb
`define ICRP_IDX_VGA_TRAP_MASK_2 8'hbc
`define ICRP_IDX_VGA_TRAP_MASK_3 8'hbd
`define ICRP_IDX_CONFIG_1 8'hc1
`define ICRP_IDX_CONFIG_2 8'hc2
`define ICRP_IDX_CONFIG_3 8'hc3
`define ICRP_IDX_SMM_REGION_0 8'hcd
`define ICRP_IDX_SMM_REGION_1 8'hce
`define ICRP_IDX_SMM_REGION_2 8'hcf
`define ICRP_IDX_CONFIG_4 8'he8
`define ICRP_IDX_CONFIG_7 8'heb
`define ICRP_IDX_DEVICE_IDENT_0 8'hfe
`define ICRP_IDX_DEVICE_IDENT_1 8'hff
`define ICRP_IDX_BASE_HIGH 4'hc

`define ICRP_RST_PERF_CONTROL 8'h07
`define ICRP_RST_CONFIG_4 8'h85
`define ICRP_RST_ZERO 8'h00

// writable bits; reserved bits read as zero
`define ICRP_WMASK_CONFIG_1 8'h06
`define ICRP_WMASK_CONFIG_2 8'h9c
`define ICRP_WMASK_CONFIG_3 8'hf3
`define ICRP_WMASK_CONFIG_4 8'hdf
`define ICRP_WMASK_CONFIG_7 8'h05
`define ICRP_WMASK_GRAPHICS 8'h0f
`define ICRP_WMASK_VGA_TRAP 8'h07

`define ICRP_BIT_MAP_ENABLE 4
`define ICRP_BIT_CONFIG_LOCK 0

// identification codes, values arbitrary
`define ICRP_IDENT_DEVICE 4'h5
`define ICRP_IDENT_STEPPING 4'h1
`define ICRP_IDENT_REVISION 4'h2

`endif

// [hdl/icrp_pkg.sv]
// types of the indexed configuration register port
package icrp_pkg;

    typedef enum logic [4:0]
    {
        SEL_NONE = 5'h00,
        SEL_PERF = 5'h01,
        SEL_HDR0 = 5'h02,
        SEL_HDR1 = 5'h03,
        SEL_HDR2 = 5'h04,
        SEL_HDR3 = 5'h05,
        SEL_GFX = 5'h06,
        SEL_VTRAP = 5'h07,
        SEL_VMASK0 = 5'h08,
        SEL_VMASK1 = 5'h09,
        SEL_VMASK2 = 5'h0a,
        SEL_VMASK3 = 5'h0b,
        SEL_CFG1 = 5'h0c,
        SEL_CFG2 = 5'h0d,
        SEL_CFG3 = 5'h0e,
        SEL_REGION0 = 5'h0f,
        SEL_REGION1 = 5'h10,
        SEL_REGION2 = 5'h11,
        SEL_CFG4 = 5'h12,
        SEL_CFG7 = 5'h13,
        SEL_IDENT0 = 5'h14,
        SEL_IDENT1 = 5'h15
    } icrp_sel_t;

    typedef struct packed
    {
        logic [7:0] index;
        logic fresh;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] cfg3;
        logic [7:0] cfg4;
        logic [7:0] cfg7;
        logic [7:0] perf;
        logic [31:0] header;
        logic [7:0] gfx;
        logic [7:0] vtrap;
        logic [31:0] vmask;
        logic [23:0] region;
        logic [1:0] clkMode;
        logic ack;
        logic [7:0] rdata;
        logic extValid;
        logic extWrite;
        logic [15:0] extAddr;
        logic [7:0] extWdata;
    } icrp_state_t;

endpackage : icrp_pkg

// [hdl/icrp_port.sv]
// indexed configuration register bank behind I/O ports 22h and 23h
`timescale 1ns/100ps
`include "icrp_defs.svh"
module icrp_port
    import icrp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    // core I/O cycle request
    input wire logic ioValid,
    input wire logic ioWrite,
    input wire logic [15:0] ioAddr,
    input wire logic [7:0] ioWdata,
    input wire logic [1:0] clkModeStatus,
    // internal answer
    output logic ioAck,
    output logic [7:0] ioRdata,
    // forwarded external I/O cycle
    output logic extValid,
    output logic extWrite,
    output logic [15:0] extAddr,
    output logic [7:0] extWdata,
    // configuration control fields
    output logic [1:0] smmAccessCtl,
    output logic suspendPinsEnable,
    output logic writeThroughRegionCtl,
    output logic suspendOnHalt,
    output logic writebackModeLock,
    output logic [2:0] lowPowerSelect,
    output logic extendedMapEnable,
    output logic nmiEnable,
    output logic smmConfigLock,
    output logic cpuIdentEnable,
    output logic smmNestingEnable,
    output logic translationCacheEnable,
    output logic memoryBypass,
    output logic [2:0] ioRecoveryTime,
    output logic nmiControl,
    output logic multimediaExtEnable,
    output logic [7:0] perfControl,
    // SMM and graphics fields
    output logic [19:0] smmRegionBase,
    output logic [3:0] smmRegionSize,
    output logic [31:0] smmHeaderAddr,
    output logic [1:0] scratchpadSize,
    output logic [1:0] graphicsBaseCode,
    output logic [2:0] vgaTrapEnable,
    output logic [31:0] vgaTrapMask
);

    icrp_state_t st;
    icrp_state_t next_st;
    logic claimed;
    icrp_sel_t regSel;
    logic isIndexWr;
    logic isData;
    logic internalHit;
    logic mapOpen;
    logic lockShut;
    logic [7:0] dataWr;
    logic [7:0] ident0;
    logic [7:0] ident1;

    // merge writable bits of a new value into an old one
    function automatic logic [7:0] icrp_merge(input logic [7:0] oldVal, input logic [7:0] newVal,
        input logic [7:0] mask);
        icrp_merge = (oldVal & ~mask) | (newVal & mask);
    endfunction : icrp_merge

    icrp_decode decoder
    (
        .index(st.index),
        .extendedMapEnable(st.cfg3[`ICRP_BIT_MAP_ENABLE]),
        .claimed(claimed),
        .regSel(regSel)
    );

    // cycle classification
    always_comb
    begin
        isIndexWr = ioValid && ioWrite && (ioAddr == `ICRP_PORT_INDEX);
        isData = ioValid && (ioAddr == `ICRP_PORT_DATA);
        // only a fresh index lets a data access reach the bank
        internalHit = isData && st.fresh && claimed;
        // map enable and config lock both live in config 3
        mapOpen = st.cfg3[`ICRP_BIT_MAP_ENABLE];
        lockShut = st.cfg3[`ICRP_BIT_CONFIG_LOCK];
        dataWr = ioWdata;
    end

    // identification bytes built from constants and sampled clock mode
    always_comb
    begin
        ident0 = {`ICRP_IDENT_DEVICE, 1'b0, st.clkMode[1], 1'b0, st.clkMode[0]};
        ident1 = {`ICRP_IDENT_STEPPING, `ICRP_IDENT_REVISION};
    end

    // next-state logic for the whole bank
    always_comb
    begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.extValid = 1'b0;
        next_st.clkMode = clkModeStatus;
        // index port write selects the target register
        if (isIndexWr)
        begin
            next_st.index = ioWdata;
            next_st.fresh = 1'b1;
            next_st.ack = 1'b1;
            next_st.rdata = 8'h00;
        end
        else if (internalHit && ioWrite)
        begin
            // each data access consumes the index selection
            next_st.fresh = 1'b0;
            next_st.ack = 1'b1;
            next_st.rdata = 8'h00;
            // blocked writes leave the register untouched
            unique case (regSel)
                SEL_CFG1:
                begin
                    if (!lockShut)
                    begin
                        next_st.cfg1 = icrp_merge(st.cfg1, dataWr, `ICRP_WMASK_CONFIG_1);
                    end
                end
                SEL_CFG2:
                begin
                    next_st.cfg2 = icrp_merge(st.cfg2, dataWr, `ICRP_WMASK_CONFIG_2);
                end
                SEL_CFG3:
                begin
                    // config 3 layout; once locked it stays so until reset
                    if (!lockShut)
                    begin
                        next_st.cfg3 = icrp_merge(st.cfg3, dataWr, `ICRP_WMASK_CONFIG_3);
                    end
                end
                SEL_CFG4:
                begin
                    if (mapOpen)
                    begin
                        next_st.cfg4 = icrp_merge(st.cfg4, dataWr, `ICRP_WMASK_CONFIG_4);
                    end
                end
                SEL_CFG7:
                begin
                    // only bits 2 and 0 exist
                    next_st.cfg7 = icrp_merge(st.cfg7, dataWr, `ICRP_WMASK_CONFIG_7);
                end
                SEL_PERF:
                begin
                    if (mapOpen)
                    begin
                        next_st.perf = dataWr;
                    end
                end
                SEL_HDR0, SEL_HDR1, SEL_HDR2, SEL_HDR3:
                begin
                    // header address, low byte at lowest index
                    if (mapOpen)
                    begin
                        unique case (regSel)
                            SEL_HDR0: next_st.header[7:0] = dataWr;
                            SEL_HDR1: next_st.header[15:8] = dataWr;
                            SEL_HDR2: next_st.header[23:16] = dataWr;
                            default: next_st.header[31:24] = dataWr;
                        endcase
                    end
                end
                SEL_GFX:
                begin
                    if (mapOpen)
                    begin
                        next_st.gfx = icrp_merge(st.gfx, dataWr, `ICRP_WMASK_GRAPHICS);
                    end
                end
                SEL_VTRAP:
                begin
                    next_st.vtrap = icrp_merge(st.vtrap, dataWr, `ICRP_WMASK_VGA_TRAP);
                end
                SEL_VMASK0: next_st.vmask[7:0] = dataWr;
                SEL_VMASK1: next_st.vmask[15:8] = dataWr;
                SEL_VMASK2: next_st.vmask[23:16] = dataWr;
                SEL_VMASK3: next_st.vmask[31:24] = dataWr;
                SEL_REGION0, SEL_REGION1, SEL_REGION2:
                begin
                    // region base most significant byte first, lock-gated
                    if (!lockShut)
                    begin
                        unique case (regSel)
                            SEL_REGION0: next_st.region[23:16] = dataWr;
                            SEL_REGION1: next_st.region[15:8] = dataWr;
                            default: next_st.region[7:0] = dataWr;
                        endcase
                    end
                end
                // identification and unused indices ignore writes
                SEL_IDENT0, SEL_IDENT1, SEL_NONE:
                begin
                    next_st.fresh = 1'b0;
                end
            endcase
        end
        else if (internalHit)
        begin
            // read of the selected register
            next_st.fresh = 1'b0;
            next_st.ack = 1'b1;
            unique case (regSel)
                SEL_CFG1: next_st.rdata = st.cfg1;
                SEL_CFG2: next_st.rdata = st.cfg2;
                SEL_CFG3: next_st.rdata = st.cfg3;
                SEL_CFG4: next_st.rdata = st.cfg4;
                SEL_CFG7: next_st.rdata = st.cfg7;
                SEL_PERF: next_st.rdata = st.perf;
                SEL_HDR0: next_st.rdata = st.header[7:0];
                SEL_HDR1: next_st.rdata = st.header[15:8];
                SEL_HDR2: next_st.rdata = st.header[23:16];
                SEL_HDR3: next_st.rdata = st.header[31:24];
                SEL_GFX: next_st.rdata = st.gfx;
                SEL_VTRAP: next_st.rdata = st.vtrap;
                SEL_VMASK0: next_st.rdata = st.vmask[7:0];
                SEL_VMASK1: next_st.rdata = st.vmask[15:8];
                SEL_VMASK2: next_st.rdata = st.vmask[23:16];
                SEL_VMASK3: next_st.rdata = st.vmask[31:24];
                SEL_REGION0: next_st.rdata = st.region[23:16];
                SEL_REGION1: next_st.rdata = st.region[15:8];
                SEL_REGION2: next_st.rdata = st.region[7:0];
                SEL_IDENT0: next_st.rdata = ident0;
                SEL_IDENT1: next_st.rdata = ident1;
                SEL_NONE: next_st.rdata = 8'h00;
            endcase
        end
        else if (ioValid)
        begin
            // stale or unclaimed data access, or any other port, goes off-chip
            // unclaimed indices end up here too
            if (isData)
            begin
                next_st.fresh = 1'b0;
            end
            next_st.extValid = 1'b1;
            next_st.extWrite = ioWrite;
            next_st.extAddr = ioAddr;
            next_st.extWdata = ioWdata;
        end
        if (rst)
        begin
            next_st = '0;
            next_st.perf = `ICRP_RST_PERF_CONTROL;
            next_st.cfg4 = `ICRP_RST_CONFIG_4;
            next_st.cfg1 = `ICRP_RST_ZERO;
            next_st.cfg2 = `ICRP_RST_ZERO;
            next_st.cfg3 = `ICRP_RST_ZERO;
            next_st.cfg7 = `ICRP_RST_ZERO;
        end
    end

    // the single state register; reset handled above as a synchronous load
    always_ff @(posedge clk_sys)
    begin
        st <= next_st;
    end

    // outputs straight from state flops
    assign ioAck = st.ack;
    assign ioRdata = st.rdata;
    assign extValid = st.extValid;
    assign extWrite = st.extWrite;
    assign extAddr = st.extAddr;
    assign extWdata = st.extWdata;
    assign smmAccessCtl = st.cfg1[2:1];
    assign suspendPinsEnable = st.cfg2[7];
    assign writeThroughRegionCtl = st.cfg2[4];
    assign suspendOnHalt = st.cfg2[3];
    assign writebackModeLock = st.cfg2[2];
    assign lowPowerSelect = st.cfg3[7:5];
    assign extendedMapEnable = st.cfg3[`ICRP_BIT_MAP_ENABLE];
    assign nmiEnable = st.cfg3[1];
    assign smmConfigLock = st.cfg3[`ICRP_BIT_CONFIG_LOCK];
    assign cpuIdentEnable = st.cfg4[7];
    assign smmNestingEnable = st.cfg4[6];
    assign translationCacheEnable = st.cfg4[4];
    assign memoryBypass = st.cfg4[3];
    assign ioRecoveryTime = st.cfg4[2:0];
    assign nmiControl = st.cfg7[2];
    assign multimediaExtEnable = st.cfg7[0];
    assign perfControl = st.perf;
    assign smmRegionBase = st.region[23:4];
    assign smmRegionSize = st.region[3:0];
    assign smmHeaderAddr = st.header;
    assign scratchpadSize = st.gfx[3:2];
    assign graphicsBaseCode = st.gfx[1:0];
    assign vgaTrapEnable = st.vtrap[2:0];
    assign vgaTrapMask = st.vmask;

endmodule : icrp_port

// [verification/icrp_core_model.sv]
// processor core model issuing I/O port cycles
`timescale 1ns/100ps
module icrp_core_model
(
    input wire logic clk_sys,
    output logic ioValid,
    output logic ioWrite,
    output logic [15:0] ioAddr,
    output logic [7:0] ioWdata,
    input wire logic ioAck,
    input wire logic [7:0] ioRdata,
    input wire logic extValid
);
    // idle bus at time zero
    initial
    begin
        ioValid = 1'b0;
        ioWrite = 1'b0;
        ioAddr = 16'h0000;
        ioWdata = 8'h00;
    end

    // one cycle: answer taken while it pulses, then lines inverted
    task io(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic ack, output logic ext, output logic [7:0] rd);
        @(negedge clk_sys);
        ioValid = 1'b1;
        ioWrite = w;
        ioAddr = a;
        ioWdata = d;
        @(negedge clk_sys);
        ack = ioAck;
        ext = extValid;
        rd = ioRdata;
        ioValid = 1'b0;
        ioWrite = ~w;
        ioAddr = ~a;
        ioWdata = ~d;
    endtask : io

    task reg_write(input logic [7:0] idx, input logic [7:0] d, output logic ack, output logic ext);
        logic [7:0] rd;
        io(1'b1, 16'h0022, idx, ack, ext, rd);
        io(1'b1, 16'h0023, d, ack, ext, rd);
    endtask : reg_write

    task reg_read(input logic [7:0] idx, output logic [7:0] rd, output logic ack, output logic ext);
        io(1'b1, 16'h0022, idx, ack, ext, rd);
        io(1'b0, 16'h0023, 8'h00, ack, ext, rd);
    endtask : reg_read
endmodule : icrp_core_model

// [verification/icrp_port_sva.sv]
// assertions on the pins of the indexed configuration register bank
`timescale 1ns/100ps
`include "icrp_defs.svh"
module icrp_port_sva
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ioValid,
    input wire logic ioWrite,
    input wire logic [15:0] ioAddr,
    input wire logic [7:0] ioWdata,
    input wire logic ioAck,
    input wire logic [7:0] ioRdata,
    input wire logic extValid,
    input wire logic [15:0] extAddr,
    input wire logic extendedMapEnable,
    input wire logic smmConfigLock,
    input wire logic [2:0] lowPowerSelect,
    input wire logic [7:0] perfControl,
    input wire logic cpuIdentEnable,
    input wire logic [2:0] ioRecoveryTime,
    input wire logic [31:0] vgaTrapMask
);
    logic armed;
    logic [7:0] idx;
    logic dataCyc;
    logic claimIdx;

    // own copy of the fresh flag and index, so a stuck design flag cannot hide itself
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            armed <= 1'b0;
            idx <= 8'h00;
        end
        else if (ioValid && ioAddr == 16'h0023)
            armed <= 1'b0;
        else if (ioValid && ioWrite && ioAddr == 16'h0022)
        begin
            armed <= 1'b1;
            idx <= ioWdata;
        end
    end

    // data port cycle and the always-claimed index set
    assign dataCyc = ioValid && ioAddr == 16'h0023;
    assign claimIdx = idx[7:4] == 4'hc || idx >= 8'hfe;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_answer_one: assert property (ioValid |=> ioAck != extValid)
        else $error("internal answer and forward not exclusive");
    chk_quiet_idle: assert property (!ioValid |=> !ioAck && !extValid)
        else $error("answer without request");
    chk_stale_data: assert property (dataCyc && !armed |=> extValid && extAddr == 16'h0023)
        else $error("stale data access not forwarded");
    chk_unclaimed_index: assert property (dataCyc && armed && !extendedMapEnable && !claimIdx |=> extValid)
        else $error("unclaimed index not forwarded");
    chk_claimed_index: assert property (dataCyc && armed && claimIdx |=> ioAck && !extValid)
        else $error("claimed index not answered");
    chk_index_taken: assert property (ioValid && ioWrite && ioAddr == 16'h0022 |=> ioAck && ioRdata == 8'h00)
        else $error("index write not taken");
    chk_other_port: assert property (ioValid && ioAddr != 16'h0023 && !(ioWrite && ioAddr == 16'h0022)
        |=> extValid && extAddr == $past(ioAddr))
        else $error("foreign port not forwarded");
    chk_reset_load: assert property (disable iff (1'b0) rst |=> perfControl == 8'h07 && cpuIdentEnable
        && ioRecoveryTime == 3'h5 && !extendedMapEnable && !smmConfigLock && vgaTrapMask == 32'h0)
        else $error("wrong reset values");
    chk_lock_blocks: assert property (dataCyc && ioWrite && armed && idx == 8'hc3 && smmConfigLock
        |=> smmConfigLock && $stable(lowPowerSelect))
        else $error("locked register changed");
    chk_extended_map_enable_gate: assert property (!extendedMapEnable |=> $stable(perfControl))
        else $error("gated register changed");
    chk_ident_fixed: assert property (dataCyc && !ioWrite && armed && idx == 8'hff
        |=> ioRdata == {`ICRP_IDENT_STEPPING, `ICRP_IDENT_REVISION})
        else $error("wrong identification code");
endmodule : icrp_port_sva

bind icrp_port icrp_port_sva u_sva (.clk_sys(clk_sys), .rst(rst), .ioValid(ioValid), .ioWrite(ioWrite),
    .ioAddr(ioAddr), .ioWdata(ioWdata), .ioAck(ioAck), .ioRdata(ioRdata), .extValid(extValid),
    .extAddr(extAddr), .extendedMapEnable(extendedMapEnable), .smmConfigLock(smmConfigLock),
    .lowPowerSelect(lowPowerSelect), .perfControl(perfControl), .cpuIdentEnable(cpuIdentEnable),
    .ioRecoveryTime(ioRecoveryTime), .vgaTrapMask(vgaTrapMask));

// [verification/test_indexed_config_register_port.sv]
// self-checking bench of the indexed configuration register bank
`timescale 1ns/100ps
module test_indexed_config_register_port;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] clkModeStatus = 2'b10;
    logic ioValid, ioWrite, ioAck, extValid, extWrite, ack, ext;
    logic [15:0] ioAddr, extAddr;
    logic [7:0] ioWdata, ioRdata, extWdata, perfControl, rd;
    logic [1:0] smmAccessCtl, scratchpadSize, graphicsBaseCode;
    logic suspendPinsEnable, writeThroughRegionCtl, suspendOnHalt, writebackModeLock;
    logic extendedMapEnable, nmiEnable, smmConfigLock, cpuIdentEnable, smmNestingEnable;
    logic translationCacheEnable, memoryBypass, nmiControl, multimediaExtEnable;
    logic [2:0] lowPowerSelect, ioRecoveryTime, vgaTrapEnable;
    logic [19:0] smmRegionBase;
    logic [3:0] smmRegionSize;
    logic [31:0] smmHeaderAddr, vgaTrapMask;
    int failures = 0;
    int samplesChecked = 0;
    int cycles = 0;
    // rows: index, value written, value read back
    localparam logic [23:0] ROWS [21] = '{24'h20a5a5, 24'hb01111, 24'hb12222, 24'hb23333, 24'hb34444,
        24'hb8ff0f, 24'hb9ff07, 24'hba0101, 24'hbb0202, 24'hbc0303, 24'hbd0404, 24'hc1ff06, 24'hc2ff9c,
        24'hcd1212, 24'hce3434, 24'hcf5656, 24'he8ffdf, 24'hebff05, 24'hc5ff00, 24'hfeff54, 24'hff0012};

    always #20 clk_sys = ~clk_sys;
    icrp_core_model u_core (.clk_sys(clk_sys), .ioValid(ioValid), .ioWrite(ioWrite), .ioAddr(ioAddr),
        .ioWdata(ioWdata), .ioAck(ioAck), .ioRdata(ioRdata), .extValid(extValid));

    icrp_port u_dut (.clk_sys(clk_sys), .rst(rst), .ioValid(ioValid), .ioWrite(ioWrite), .ioAddr(ioAddr),
        .ioWdata(ioWdata), .clkModeStatus(clkModeStatus), .ioAck(ioAck), .ioRdata(ioRdata),
        .extValid(extValid), .extWrite(extWrite), .extAddr(extAddr), .extWdata(extWdata),
        .smmAccessCtl(smmAccessCtl), .suspendPinsEnable(suspendPinsEnable),
        .writeThroughRegionCtl(writeThroughRegionCtl), .suspendOnHalt(suspendOnHalt),
        .writebackModeLock(writebackModeLock), .lowPowerSelect(lowPowerSelect),
        .extendedMapEnable(extendedMapEnable), .nmiEnable(nmiEnable), .smmConfigLock(smmConfigLock),
        .cpuIdentEnable(cpuIdentEnable), .smmNestingEnable(smmNestingEnable),
        .translationCacheEnable(translationCacheEnable), .memoryBypass(memoryBypass),
        .ioRecoveryTime(ioRecoveryTime), .nmiControl(nmiControl), .multimediaExtEnable(multimediaExtEnable),
        .perfControl(perfControl), .smmRegionBase(smmRegionBase), .smmRegionSize(smmRegionSize),
        .smmHeaderAddr(smmHeaderAddr), .scratchpadSize(scratchpadSize), .graphicsBaseCode(graphicsBaseCode),
        .vgaTrapEnable(vgaTrapEnable), .vgaTrapMask(vgaTrapMask));

    task final_report;
        if (failures == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        samplesChecked++;
        if (seen !== expv)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, expv, seen);
        end
    endtask : check
    // reset held for two cycles, driven at the falling edge
    task pulse_reset;
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
    endtask : pulse_reset

    // port views of every reset value except the SMM header address
    task check_reset;
        check("perf", perfControl, 32'(8'h07));
        check("cfg4", 32'({cpuIdentEnable, smmNestingEnable, translationCacheEnable, memoryBypass,
            ioRecoveryTime}), 32'h45);
        check("cfg3", 32'({lowPowerSelect, extendedMapEnable, nmiEnable, smmConfigLock}), 32'h0);
        check("cfg1 cfg2", 32'({suspendPinsEnable, writeThroughRegionCtl, suspendOnHalt, writebackModeLock,
            smmAccessCtl}), 32'h0);
        check("cfg7", 32'({nmiControl, multimediaExtEnable}), 32'h0);
        check("region", 32'({smmRegionBase, smmRegionSize}), 32'h0);
        check("vga mask", vgaTrapMask, 32'h0);
        check("gfx trap", 32'({vgaTrapEnable, scratchpadSize, graphicsBaseCode}), 32'h0);
    endtask : check_reset

    // hang guard: the sequence needs well under 1000 cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            final_report();
        end
    end

    initial
    begin
        pulse_reset();
        check_reset();
        // data access with no index goes off-chip
        u_core.io(1'b0, 16'h0023, 8'h00, ack, ext, rd);
        check("stale", 32'({ack, ext, extAddr}), 32'h10023);
        // map closed: gated index forwarded, value kept; C-range index claimed
        u_core.reg_write(8'h20, 8'h00, ack, ext);
        check("perf closed", 32'({ack, ext, perfControl}), 32'h107);
        u_core.reg_read(8'hc5, rd, ack, ext);
        check("unused read", 32'({ack, ext, rd}), 32'h200);
        u_core.reg_write(8'hc3, 8'h10, ack, ext);
        check("map open", 32'({ack, extendedMapEnable}), 32'h3);
        // every register except config 3 written and read back
        for (int i = 0; i < 21; i++)
        begin
            u_core.reg_write(ROWS[i][23:16], ROWS[i][15:8], ack, ext);
            u_core.reg_read(ROWS[i][23:16], rd, ack, ext);
            check("readback", 32'({ack, ext, rd}), 32'({2'b10, ROWS[i][7:0]}));
        end
        check("region", 32'({smmRegionBase, smmRegionSize}), 32'h123456);
        check("header", smmHeaderAddr, 32'h44332211);
        check("vga mask", vgaTrapMask, 32'h04030201);
        check("gfx trap", 32'({vgaTrapEnable, scratchpadSize, graphicsBaseCode}), 32'h7f);
        check("cfg1 cfg2", 32'({suspendPinsEnable, writeThroughRegionCtl, suspendOnHalt, writebackModeLock,
            smmAccessCtl}), 32'h3f);
        check("cfg4", 32'({cpuIdentEnable, smmNestingEnable, translationCacheEnable, memoryBypass,
            ioRecoveryTime}), 32'h7f);
        check("cfg7 perf", 32'({nmiControl, multimediaExtEnable, perfControl}), 32'h3a5);
        // the index was consumed, so a second data write is forwarded whole
        u_core.io(1'b1, 16'h0023, 8'hff, ack, ext, rd);
        check("reuse", 32'({ack, ext, extWrite, extWdata}), 32'h3ff);
        // a foreign port between index and data leaves the index armed
        u_core.io(1'b1, 16'h0022, 8'hc2, ack, ext, rd);
        u_core.io(1'b1, 16'h0080, 8'haa, ack, ext, rd);
        check("foreign", 32'({ext, extAddr}), 32'h10080);
        u_core.io(1'b0, 16'h0023, 8'h00, ack, ext, rd);
        check("armed kept", 32'({ack, rd}), 32'h19c);
        // lock set: locked writes ignored, ungated config 2 still writable
        u_core.reg_write(8'hc3, 8'hff, ack, ext);
        check("cfg3", 32'({lowPowerSelect, extendedMapEnable, nmiEnable, smmConfigLock}), 32'h3f);
        u_core.reg_write(8'hcd, 8'h00, ack, ext);
        u_core.reg_write(8'hc3, 8'h00, ack, ext);
        u_core.reg_write(8'hc2, 8'h00, ack, ext);
        check("locked", 32'({smmRegionBase[19:12], smmConfigLock, suspendPinsEnable}), 32'h4a);
        clkModeStatus = 2'b01;
        u_core.reg_read(8'hfe, rd, ack, ext);
        check("clock mode", 32'(rd), 32'h51);
        // second reset in mid-run clears the lock and reloads defaults
        pulse_reset();
        check_reset();
        final_report();
    end
endmodule : test_indexed_config_register_port
